/* core/tcc_pkg.sv */
// constants shared by the compare/capture register set
// assumes a 16-bit timer counter per channel supplied from outside
package tcc_pkg;
  // ==========================================================
  // geometry
  localparam int TCC_W = 16;
  localparam int TCC_CHANNELS = 5;
  localparam int TCC_REGS = 10;
  localparam int TCC_FIRST_BUF_CH = 3;
  localparam int TCC_BUF_SEL_W = 4;
  // ==========================================================
  // reset values
  localparam logic [15:0] TCC_GR_RESET = 16'hffff;
  localparam logic [15:0] TCC_BR_RESET = 16'hffff;
  // ==========================================================
  // register address: addr[4:2] channel, addr[1:0] register select
  localparam int TCC_ADDR_W = 5;
  localparam int TCC_ADDR_CH_LSB = 2;
  localparam logic [1:0] TCC_SEL_GR_A = 2'h0;
  localparam logic [1:0] TCC_SEL_GR_B = 2'h1;
  localparam logic [1:0] TCC_SEL_BR_A = 2'h2;
  localparam logic [1:0] TCC_SEL_BR_B = 2'h3;
  localparam int TCC_SEL_BR_BIT = 1;
  // ==========================================================
  // io control field, 3 bits per register
  localparam int TCC_IO_W = 3;
  localparam int TCC_IO_CFG_W = 8;
  localparam int TCC_IO_A_LSB = 0;
  localparam int TCC_IO_B_LSB = 4;
  localparam int TCC_IO_CAP_BIT = 2;
  localparam logic [1:0] TCC_OUT_NONE = 2'h0;
  localparam logic [1:0] TCC_OUT_ZERO = 2'h1;
  localparam logic [1:0] TCC_OUT_ONE = 2'h2;
  localparam logic [1:0] TCC_OUT_TOGGLE = 2'h3;
  localparam logic [1:0] TCC_CAP_RISE = 2'h0;
  localparam logic [1:0] TCC_CAP_FALL = 2'h1;
  // ==========================================================
  // counter clear select, 2 bits per channel
  localparam int TCC_CCLR_W = 2;
  localparam logic [1:0] TCC_CCLR_NONE = 2'h0;
  localparam logic [1:0] TCC_CCLR_A = 2'h1;
  localparam logic [1:0] TCC_CCLR_B = 2'h2;
endpackage

/* core/tcc_gr_unit.sv */
// one compare/capture register with its optional buffer register
// assumes counter, pin input and configuration are synchronous to clock
`timescale 1ns/1ps
module tcc_gr_unit #(
  parameter bit HAS_BUFFER = 1'b0
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic standby,
  input wire logic [tcc_pkg::TCC_W-1:0] counter,
  input wire logic [tcc_pkg::TCC_IO_W-1:0] io_sel,
  input wire logic pwm_mode,
  input wire logic buf_en,
  input wire logic cap_in,
  input wire logic [1:0] wr_gr,
  input wire logic [1:0] wr_br,
  input wire logic [tcc_pkg::TCC_W-1:0] wdata,
  input wire logic flag_clear,
  output logic [tcc_pkg::TCC_W-1:0] gr,
  output logic [tcc_pkg::TCC_W-1:0] br,
  output logic match_flag,
  output logic hit,
  output logic pin_out,
  output logic pin_oe_n
);
  import tcc_pkg::*;

  typedef struct packed {
    logic [15:0] gr;
    logic [15:0] br;
    logic flag;
    logic pin;
    logic oe_n;
    logic cap_prev;
    logic eq_prev;
  } tcc_unit_s;

  tcc_unit_s s;
  tcc_unit_s next_s;
  logic cap_mode;
  logic match;
  logic cap;
  logic buffered;
  logic eq;

  // ==========================================================
  // behaviour
  always_comb begin
    next_s = s;
    // pwm modes take the io selection out of play
    cap_mode = !pwm_mode && io_sel[TCC_IO_CAP_BIT];
    buffered = HAS_BUFFER && buf_en;
    eq = (counter == s.gr);
    // edge of equality only: a prescaled counter sits on one value many cycles
    match = !cap_mode && eq && !s.eq_prev;
    if (io_sel[1]) begin
      cap = cap_mode && (cap_in != s.cap_prev);
    end else if (io_sel[0]) begin
      cap = cap_mode && !cap_in && s.cap_prev;
    end else begin
      cap = cap_mode && cap_in && !s.cap_prev;
    end
    next_s.cap_prev = cap_in;
    next_s.eq_prev = eq;
    if (wr_gr[0]) next_s.gr[7:0] = wdata[7:0];
    if (wr_gr[1]) next_s.gr[15:8] = wdata[15:8];
    if (HAS_BUFFER && wr_br[0]) next_s.br[7:0] = wdata[7:0];
    if (HAS_BUFFER && wr_br[1]) next_s.br[15:8] = wdata[15:8];
    // hardware transfers win over a bus write in the same cycle
    if (match && buffered) next_s.gr = s.br;
    if (cap) begin
      next_s.gr = counter;
      if (buffered) next_s.br = s.gr;
    end
    if (flag_clear) next_s.flag = 1'b0;
    if (match || cap) next_s.flag = 1'b1;
    next_s.oe_n = !(!pwm_mode && !io_sel[TCC_IO_CAP_BIT] && io_sel[1:0] != TCC_OUT_NONE);
    if (match && !pwm_mode) begin
      case (io_sel[1:0])
        TCC_OUT_ZERO: next_s.pin = 1'b0;
        TCC_OUT_ONE: next_s.pin = 1'b1;
        TCC_OUT_TOGGLE: next_s.pin = !s.pin;
        default: next_s.pin = s.pin;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n || standby) begin
      s <= '{gr: TCC_GR_RESET, br: TCC_BR_RESET, flag: 1'b0, pin: 1'b0, oe_n: 1'b1,
             cap_prev: 1'b0, eq_prev: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign gr = s.gr;
  assign br = s.br;
  assign match_flag = s.flag;
  assign pin_out = s.pin;
  assign pin_oe_n = s.oe_n;
  assign hit = match || cap;

  // ==========================================================
  // checks
  sequence s_capture;
    cap && !standby;
  endsequence
  sequence s_match_buf;
    match && buffered && !cap && !standby;
  endsequence

  AST_CAP_LATCH: assert property (@(posedge clock) disable iff (!reset_n)
    s_capture |=> gr == $past(counter)) else $error("capture did not latch counter");
  AST_CAP_FLAG: assert property (@(posedge clock) disable iff (!reset_n)
    s_capture |=> match_flag) else $error("capture flag not set with latch");
  AST_CMP_FLAG: assert property (@(posedge clock) disable iff (!reset_n)
    (match && !standby) |=> match_flag) else $error("compare match flag missing");
  AST_BUF_LOAD: assert property (@(posedge clock) disable iff (!reset_n)
    s_match_buf |=> gr == $past(br)) else $error("buffer not moved on match");
  AST_CAP_BUF: assert property (@(posedge clock) disable iff (!reset_n)
    (s_capture ##0 buffered) |=> br == $past(gr)) else $error("old value not buffered");
  AST_STANDBY_INIT: assert property (@(posedge clock) disable iff (!reset_n)
    standby |=> gr == 16'hffff && br == 16'hffff && pin_oe_n) else $error("standby init");
  AST_PWM_IGNORE: assert property (@(posedge clock) disable iff (!reset_n)
    pwm_mode [*2] |-> !cap && pin_oe_n) else $error("io control used in pwm mode");
  AST_PIN_ONE: assert property (@(posedge clock) disable iff (!reset_n)
    (match && !pwm_mode && !standby && io_sel == 3'h2) |=> pin_out && !pin_oe_n)
    else $error("pin not set on match");
endmodule

/* core/tcc_top.sv */
// compare/capture and buffer registers of a five-channel 16-bit timer
// assumes counters, mode bits and status clears come from the rest of the timer
`timescale 1ns/1ps
module tcc_top (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic standby,
  input wire logic [tcc_pkg::TCC_CHANNELS*tcc_pkg::TCC_W-1:0] channel_counter,
  input wire logic [tcc_pkg::TCC_CHANNELS*tcc_pkg::TCC_IO_CFG_W-1:0] io_control_config,
  input wire logic [tcc_pkg::TCC_CHANNELS-1:0] pwm_mode,
  input wire logic buffer_select_ch3_a,
  input wire logic buffer_select_ch3_b,
  input wire logic buffer_select_ch4_a,
  input wire logic buffer_select_ch4_b,
  input wire logic [tcc_pkg::TCC_CHANNELS*tcc_pkg::TCC_CCLR_W-1:0] counter_clear_select,
  input wire logic [tcc_pkg::TCC_REGS-1:0] capture_in,
  input wire logic [tcc_pkg::TCC_REGS-1:0] flag_clear,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [tcc_pkg::TCC_ADDR_W-1:0] bus_addr,
  input wire logic [1:0] bus_be,
  input wire logic [tcc_pkg::TCC_W-1:0] bus_wdata,
  output logic [tcc_pkg::TCC_W-1:0] bus_rdata,
  output logic [tcc_pkg::TCC_REGS-1:0] match_flag,
  output logic [tcc_pkg::TCC_REGS-1:0] pin_out,
  output logic [tcc_pkg::TCC_REGS-1:0] pin_oe_n,
  output logic [tcc_pkg::TCC_CHANNELS-1:0] counter_clear
);
  import tcc_pkg::*;

  typedef struct packed {
    logic [15:0] rdata;
    logic [4:0] clr;
  } tcc_top_s;

  tcc_top_s s;
  tcc_top_s next_s;

  logic [15:0] gr_q [0:TCC_REGS-1];
  logic [15:0] br_q [0:TCC_REGS-1];
  logic [TCC_REGS-1:0] hit;
  logic [TCC_BUF_SEL_W-1:0] buf_sel;
  logic [2:0] addr_ch;
  logic [3:0] addr_idx;
  logic addr_ok;
  logic addr_br;

  // ==========================================================
  // address decode
  assign buf_sel = {buffer_select_ch4_b, buffer_select_ch4_a,
                    buffer_select_ch3_b, buffer_select_ch3_a};
  assign addr_ch = bus_addr[TCC_ADDR_W-1:TCC_ADDR_CH_LSB];
  assign addr_idx = {addr_ch, bus_addr[0]};
  assign addr_br = bus_addr[TCC_SEL_BR_BIT];
  // buffer slots exist only from the first buffered channel up
  assign addr_ok = (addr_ch < 3'(TCC_CHANNELS)) &&
                   (!addr_br || addr_ch >= 3'(TCC_FIRST_BUF_CH));

  // ==========================================================
  // register units, one per compare/capture register
  for (genvar ch = 0; ch < TCC_CHANNELS; ch++) begin : g_ch
    for (genvar ab = 0; ab < 2; ab++) begin : g_ab
      localparam int I = 2 * ch + ab;
      localparam bit BUF = (ch >= TCC_FIRST_BUF_CH);
      localparam int IO_LSB = ch * TCC_IO_CFG_W + (ab ? TCC_IO_B_LSB : TCC_IO_A_LSB);
      logic sel;
      logic [1:0] wr_gr;
      logic [1:0] wr_br;
      logic be_buf;
      assign sel = bus_wr && addr_ok && addr_idx == 4'(I);
      assign wr_gr = (sel && !addr_br) ? bus_be : 2'h0;
      assign wr_br = (sel && addr_br) ? bus_be : 2'h0;
      // channels without buffers never index the select word
      if (BUF) begin : g_buf
        assign be_buf = buf_sel[2 * (ch - TCC_FIRST_BUF_CH) + ab];
      end else begin : g_nobuf
        assign be_buf = 1'b0;
      end
      tcc_gr_unit #(
        .HAS_BUFFER(BUF)
      ) u_reg (
        .clock(clock),
        .reset_n(reset_n),
        .standby(standby),
        .counter(channel_counter[ch*TCC_W +: TCC_W]),
        .io_sel(io_control_config[IO_LSB +: TCC_IO_W]),
        .pwm_mode(pwm_mode[ch]),
        .buf_en(be_buf),
        .cap_in(capture_in[I]),
        .wr_gr(wr_gr),
        .wr_br(wr_br),
        .wdata(bus_wdata),
        .flag_clear(flag_clear[I]),
        .gr(gr_q[I]),
        .br(br_q[I]),
        .match_flag(match_flag[I]),
        .hit(hit[I]),
        .pin_out(pin_out[I]),
        .pin_oe_n(pin_oe_n[I])
      );
    end
  end

  // ==========================================================
  // read path and counter clear requests
  always_comb begin
    next_s = s;
    if (bus_rd) begin
      if (!addr_ok) begin
        next_s.rdata = 16'h0000;
      end else if (addr_br) begin
        next_s.rdata = br_q[addr_idx];
      end else begin
        next_s.rdata = gr_q[addr_idx];
      end
    end
    for (int c = 0; c < TCC_CHANNELS; c++) begin
      case (counter_clear_select[c*TCC_CCLR_W +: TCC_CCLR_W])
        TCC_CCLR_A: next_s.clr[c] = hit[2*c];
        TCC_CCLR_B: next_s.clr[c] = hit[2*c+1];
        default: next_s.clr[c] = 1'b0;
      endcase
    end
    // clear pulse is registered with the latch so the counter resets one edge later
    if (standby) next_s.clr = 5'h00;
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s <= '{rdata: 16'h0000, clr: 5'h00};
    end else begin
      s <= next_s;
    end
  end

  assign bus_rdata = s.rdata;
  assign counter_clear = s.clr;

  // ==========================================================
  // checks
  sequence s_word_wr_ch0a;
    bus_wr && bus_be == 2'h3 && bus_addr == 5'h00 && !standby;
  endsequence
  sequence s_lo_wr_ch3br;
    bus_wr && bus_be == 2'h1 && bus_addr == 5'h0e && !standby;
  endsequence

  AST_WORD_WRITE: assert property (@(posedge clock) disable iff (!reset_n)
    (s_word_wr_ch0a ##0 !hit[0]) |=> gr_q[0] == $past(bus_wdata))
    else $error("word write lost");
  AST_BYTE_WRITE: assert property (@(posedge clock) disable iff (!reset_n)
    (s_lo_wr_ch3br ##0 !hit[6]) |=>
      br_q[6] == {$past(br_q[6][15:8]), $past(bus_wdata[7:0])})
    else $error("byte write to buffer wrong");
  AST_READ_BACK: assert property (@(posedge clock) disable iff (!reset_n)
    (bus_rd && bus_addr == 5'h01) |=> bus_rdata == $past(gr_q[1]))
    else $error("read data mismatch");
  AST_NO_BUF_LOW: assert property (@(posedge clock) disable iff (!reset_n)
    (bus_rd && bus_addr == 5'h02) |=> bus_rdata == 16'h0000)
    else $error("channel 0 has no buffer");
  AST_CLEAR_A: assert property (@(posedge clock) disable iff (!reset_n)
    (hit[0] && counter_clear_select[1:0] == 2'h1 && !standby) |=> counter_clear[0])
    else $error("counter clear on register a missing");
  AST_CLEAR_NONE: assert property (@(posedge clock) disable iff (!reset_n)
    (counter_clear_select[3:2] == 2'h0) |=> !counter_clear[1])
    else $error("counter cleared while disabled");
  AST_INIT_ONES: assert property (@(posedge clock)
    !reset_n |=> gr_q[9] == 16'hffff && br_q[8] == 16'hffff && pin_oe_n == 10'h3ff)
    else $error("reset values wrong");
endmodule

/* tb/tcc_top_tb.sv */
// self-checking bench for the compare/capture register set of tcc_top
// assumes the port contract of tcc_top; inputs change on the falling edge
`timescale 1ns/1ps
module tcc_top_tb;
  import tcc_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic standby = 1'b0;
  logic [TCC_CHANNELS*TCC_W-1:0] channel_counter = '0;
  logic [TCC_CHANNELS*TCC_IO_CFG_W-1:0] io_control_config = '0;
  logic [TCC_CHANNELS-1:0] pwm_mode = '0;
  logic [3:0] bsel = '0;
  logic [TCC_CHANNELS*TCC_CCLR_W-1:0] counter_clear_select = '0;
  logic [TCC_REGS-1:0] capture_in = '0;
  logic [TCC_REGS-1:0] flag_clear = '0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [TCC_ADDR_W-1:0] bus_addr = '0;
  logic [1:0] bus_be = '0;
  logic [TCC_W-1:0] bus_wdata = '0;
  logic [TCC_W-1:0] bus_rdata;
  logic [TCC_REGS-1:0] match_flag, pin_out, pin_oe_n;
  logic [TCC_CHANNELS-1:0] counter_clear;
  int error_cnt = 0;
  int total_checks = 0;
  int cycles = 0;

  always #50 clock = ~clock;

  tcc_top i_dut (.clock(clock), .reset_n(reset_n), .standby(standby),
    .channel_counter(channel_counter), .io_control_config(io_control_config),
    .pwm_mode(pwm_mode), .buffer_select_ch3_a(bsel[0]), .buffer_select_ch3_b(bsel[1]),
    .buffer_select_ch4_a(bsel[2]), .buffer_select_ch4_b(bsel[3]),
    .counter_clear_select(counter_clear_select), .capture_in(capture_in),
    .flag_clear(flag_clear), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr),
    .bus_be(bus_be), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .match_flag(match_flag), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .counter_clear(counter_clear));

  // ==========================================================
  // shared helpers
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // generous ceiling: the whole sequence needs under two hundred cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      report_and_stop;
    end
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick;
    @(negedge clock);
  endtask

  task automatic wr(input int ch, input logic [1:0] sel, input logic [1:0] be,
                    input logic [15:0] d);
    tick;
    bus_addr = {ch[2:0], sel};
    bus_be = be;
    bus_wdata = d;
    bus_wr = 1'b1;
    tick;
    bus_wr = 1'b0;
  endtask

  // read data is registered at the taking edge, so it is settled one half cycle later
  task automatic rdchk(input int ch, input logic [1:0] sel, input logic [15:0] exp,
                       input string nm);
    tick;
    bus_addr = {ch[2:0], sel};
    bus_rd = 1'b1;
    tick;
    bus_rd = 1'b0;
    chk(nm, bus_rdata, exp);
  endtask

  task automatic set_cnt(input int ch, input logic [15:0] v);
    tick;
    channel_counter[ch*16 +: 16] = v;
    tick;
  endtask

  task automatic set_io(input int ch, input int ab, input logic [2:0] v);
    tick;
    io_control_config[ch*8+ab*4 +: 3] = v;
  endtask

  task automatic cap(input int idx, input logic lvl);
    tick;
    capture_in[idx] = lvl;
    tick;
  endtask

  // ==========================================================
  // scenarios
  task automatic test_reset;
    for (int c = 0; c < 5; c++) begin
      rdchk(c, TCC_SEL_GR_A, 16'hffff, "gr_a reset");
      rdchk(c, TCC_SEL_GR_B, 16'hffff, "gr_b reset");
    end
    for (int c = 3; c < 5; c++) begin
      rdchk(c, TCC_SEL_BR_A, 16'hffff, "br_a reset");
      rdchk(c, TCC_SEL_BR_B, 16'hffff, "br_b reset");
    end
    chk("oe_n reset", {6'h00, pin_oe_n}, 16'h03ff);
    chk("flags reset", {6'h00, match_flag}, 16'h0000);
    $display("test reset done");
  endtask

  task automatic test_bus;
    wr(4, TCC_SEL_GR_A, 2'b11, 16'h1234);
    rdchk(4, TCC_SEL_GR_A, 16'h1234, "word write");
    wr(4, TCC_SEL_GR_A, 2'b01, 16'habcd);
    rdchk(4, TCC_SEL_GR_A, 16'h12cd, "low byte");
    wr(4, TCC_SEL_GR_A, 2'b10, 16'h5600);
    rdchk(4, TCC_SEL_GR_A, 16'h56cd, "high byte");
    wr(3, TCC_SEL_BR_B, 2'b10, 16'h7700);
    rdchk(3, TCC_SEL_BR_B, 16'h77ff, "buffer byte");
    wr(3, TCC_SEL_BR_A, 2'b01, 16'hbb55);
    rdchk(3, TCC_SEL_BR_A, 16'hff55, "buffer low byte");
    wr(0, TCC_SEL_BR_A, 2'b11, 16'h4321);
    rdchk(0, TCC_SEL_BR_A, 16'h0000, "no buffer ch0");
    rdchk(5, TCC_SEL_GR_A, 16'h0000, "unmapped channel");
    $display("test bus done");
  endtask

  task automatic test_compare;
    logic [2:0] md [4] = '{3'b001, 3'b011, 3'b011, 3'b010};
    logic lv [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    set_io(0, 0, 3'b010);
    counter_clear_select = 10'h001;
    wr(0, TCC_SEL_GR_A, 2'b11, 16'h0040);
    set_cnt(0, 16'h0040);
    chk("match flag", {15'h0, match_flag[0]}, 16'h0001);
    chk("pin drive 1", {15'h0, pin_out[0]}, 16'h0001);
    chk("pin enabled", {15'h0, pin_oe_n[0]}, 16'h0000);
    chk("clear pulse", {11'h0, counter_clear}, 16'h0001);
    tick;
    chk("clear one cycle", {11'h0, counter_clear}, 16'h0000);
    flag_clear[0] = 1'b1;
    tick;
    flag_clear[0] = 1'b0;
    chk("flag cleared", {15'h0, match_flag[0]}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      set_cnt(0, 16'h0000);
      set_io(0, 0, md[i]);
      set_cnt(0, 16'h0040);
      chk("pin mode", {15'h0, pin_out[0]}, {15'h0, lv[i]});
    end
    $display("test compare done");
  endtask

  task automatic test_capture;
    set_io(1, 1, 3'b100);
    set_cnt(1, 16'h0777);
    cap(3, 1'b1);
    chk("capture flag", {15'h0, match_flag[3]}, 16'h0008 >> 3);
    rdchk(1, TCC_SEL_GR_B, 16'h0777, "rising capture");
    set_cnt(1, 16'h0aaa);
    cap(3, 1'b0);
    rdchk(1, TCC_SEL_GR_B, 16'h0777, "wrong edge");
    set_io(1, 1, 3'b101);
    set_cnt(1, 16'h0888);
    cap(3, 1'b1);
    cap(3, 1'b0);
    rdchk(1, TCC_SEL_GR_B, 16'h0888, "falling capture");
    set_io(1, 1, 3'b110);
    set_cnt(1, 16'h0999);
    cap(3, 1'b1);
    rdchk(1, TCC_SEL_GR_B, 16'h0999, "both edges");
    $display("test capture done");
  endtask

  task automatic test_buffer;
    bsel = 4'b1001;
    wr(3, TCC_SEL_BR_A, 2'b11, 16'h0200);
    wr(3, TCC_SEL_GR_A, 2'b11, 16'h0010);
    wr(3, TCC_SEL_BR_B, 2'b11, 16'h0300);
    wr(3, TCC_SEL_GR_B, 2'b11, 16'h0020);
    set_cnt(3, 16'h0010);
    rdchk(3, TCC_SEL_GR_A, 16'h0200, "buffered reload");
    set_cnt(3, 16'h0020);
    rdchk(3, TCC_SEL_GR_B, 16'h0020, "unbuffered b");
    set_io(4, 1, 3'b100);
    wr(4, TCC_SEL_GR_B, 2'b11, 16'h0123);
    set_cnt(4, 16'h0555);
    cap(9, 1'b1);
    rdchk(4, TCC_SEL_GR_B, 16'h0555, "buffered capture");
    rdchk(4, TCC_SEL_BR_B, 16'h0123, "old value saved");
    $display("test buffer done");
  endtask

  task automatic test_pwm;
    pwm_mode[2] = 1'b1;
    set_io(2, 0, 3'b010);
    wr(2, TCC_SEL_GR_A, 2'b11, 16'h0030);
    set_cnt(2, 16'h0030);
    chk("pwm no pin", {15'h0, pin_oe_n[4]}, 16'h0001);
    set_io(2, 1, 3'b100);
    set_cnt(2, 16'h0044);
    cap(5, 1'b1);
    rdchk(2, TCC_SEL_GR_B, 16'hffff, "pwm no capture");
    $display("test pwm done");
  endtask

  task automatic test_standby;
    tick;
    standby = 1'b1;
    // the rest of the timer reinitialises its own registers alongside us
    io_control_config = '0;
    pwm_mode = '0;
    channel_counter = '0;
    tick;
    tick;
    chk("standby oe_n", {6'h00, pin_oe_n}, 16'h03ff);
    standby = 1'b0;
    rdchk(0, TCC_SEL_GR_A, 16'hffff, "standby gr");
    rdchk(3, TCC_SEL_BR_A, 16'hffff, "standby br");
    chk("oe_n after standby", {6'h00, pin_oe_n}, 16'h03ff);
    $display("test standby done");
  endtask

  initial begin
    repeat (16) @(posedge clock);
    tick;
    reset_n = 1'b1;
    test_reset;
    test_bus;
    test_compare;
    test_capture;
    test_buffer;
    test_pwm;
    test_standby;
    report_and_stop;
  end
endmodule
